// *** rtl/jix_exec.sv ***
// executor for the absolute jump and increment-file-register instructions, apb controlled
//
// Function
// - jump loads 20-bit literal into pc 20:1
// - jump reaches whole program space, no paging
// - jump literal spans 0 through 1048575
// - jump is two words: EF then F prefix
// - increment adds one, sends sum to destination
// - destination bit picks accumulator or file register
// - bank bit picks access bank or bank select
// - increment sets five flags; jump leaves flags
// - increment is one word 001010da, one cycle
// - increment address spans one byte in bank
`timescale 1ns/1ns
module jix_exec
  import jix_pkg::*;
#(
  parameter int QPH = Q_PHASES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busy_q
);
  jix_state_t        state_q;
  logic [PC_W-1:0]   pc_q;
  logic [7:0]        wreg_q;
  logic [3:0]        bank_select_reg_q;
  logic [4:0]        status_q;
  logic [15:0]       instr_q;
  logic [7:0]        lit_lo_q;
  logic              illegal_q;
  logic [1:0]        qph_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              ram_we_q;
  logic [ADDR_W-1:0] ram_waddr_q;
  logic [7:0]        ram_wdata_q;
  logic [15:0]       cur_instr_q;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire               setup_ph   = psel & ~penable;
  wire               acc_ph     = psel & penable;
  wire               wr_ph      = setup_ph & pwrite;
  wire               rd_ph      = setup_ph & ~pwrite;
  wire               hit_ctrl   = (paddr == REG_CTRL);
  wire               hit_instr  = (paddr == REG_INSTR);
  wire               hit_pc     = (paddr == REG_PC);
  wire               hit_wreg   = (paddr == REG_WREG);
  wire               hit_bank   = (paddr == REG_BANKSEL);
  wire               hit_stat   = (paddr == REG_STATUS);
  wire               hit_state  = (paddr == REG_STATE);
  wire               hit_maddr  = (paddr == REG_MEM_ADDR);
  wire               hit_mdata  = (paddr == REG_MEM_DATA);
  wire               hit_any    = hit_ctrl | hit_instr | hit_pc | hit_wreg | hit_bank
                                  | hit_stat | hit_state | hit_maddr | hit_mdata;
  wire               idle       = (state_q == JIX_IDLE);
  // writes to core state are refused while an instruction runs, except the jump second word written to the instruction register in wait2
  wire               core_wr    = wr_ph & idle;
  wire               go         = core_wr & hit_ctrl & pwdata[0];
  wire               soft_clr   = core_wr & hit_ctrl & pwdata[1];
  wire               wait2      = (state_q == JIX_WAIT2);
  wire               feed2      = wr_ph & hit_instr & wait2;

  ////////////////////////////////////////////////////////////////////////
  // instruction field decode
  wire               is_jmp1    = (cur_instr_q[15:8] == JMP_OP1);
  wire               is_jmp2    = (instr_q[15:12] == JMP_PFX2);
  wire               is_inc     = (cur_instr_q[15:10] == INC_OP);
  wire               dest_file  = cur_instr_q[OP_DEST_BIT];
  wire               use_bank   = cur_instr_q[OP_BANK_BIT];
  wire [7:0]         f_addr     = cur_instr_q[7:0];
  wire [3:0]         acc_bank   = (f_addr < ACC_SPLIT) ? 4'h0 : ACC_HI_BANK;
  wire [3:0]         eff_bank   = use_bank ? bank_select_reg_q : acc_bank;
  wire [ADDR_W-1:0]  eff_addr   = {eff_bank, f_addr};
  wire [LIT_W-1:0]   jmp_lit    = {instr_q[11:0], lit_lo_q};
  wire               q_last     = (qph_q == 2'(QPH - 1));
  wire [ADDR_W-1:0]  ram_raddr  = idle ? mem_addr_q : eff_addr;
  wire [7:0]         ram_rdata;
  wire [7:0]         inc_sum;
  wire [4:0]         inc_flags;

  jix_ram #(.AW(ADDR_W), .DW(8)) u_ram
  (
    .pclk    (pclk),
    .we      (ram_we_q),
    .waddr   (ram_waddr_q),
    .wdata   (ram_wdata_q),
    .raddr   (ram_raddr),
    .rdata_q (ram_rdata)
  );

  jix_alu u_alu
  (
    .opnd  (ram_rdata),
    .sum   (inc_sum),
    .flags (inc_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // read mux
  wire [31:0]        rd_mux =
      hit_instr ? {16'h0000, instr_q} :
      hit_pc    ? {11'h000, pc_q} :
      hit_wreg  ? {24'h000000, wreg_q} :
      hit_bank  ? {28'h0000000, bank_select_reg_q} :
      hit_stat  ? {27'h0000000, status_q} :
      hit_state ? {29'h00000000, wait2, illegal_q, ~idle} :
      hit_maddr ? {20'h00000, mem_addr_q} :
      hit_mdata ? {24'h000000, ram_rdata} : 32'h0000_0000;

  // apb answer in the access phase, one wait-free cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~hit_any;
      prdata_q  <= rd_ph ? rd_mux : prdata_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // quarter-phase counter, four phases per instruction cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      qph_q <= 2'h0;
    end
    else
    begin
      qph_q <= (idle || wait2) ? 2'h0 : qph_q + 2'h1;
    end
  end

  // sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= JIX_IDLE;
    end
    else
    begin
      case (state_q)
        JIX_IDLE  : state_q <= go ? JIX_DEC : JIX_IDLE;
        JIX_DEC   : state_q <= !q_last ? JIX_DEC : is_jmp1 ? JIX_WAIT2 : JIX_IDLE;
        JIX_WAIT2 : state_q <= feed2 ? JIX_EXEC : JIX_WAIT2;
        JIX_EXEC  : state_q <= !q_last ? JIX_EXEC : is_jmp2 ? JIX_NOP : JIX_IDLE;
        JIX_NOP   : state_q <= q_last ? JIX_IDLE : JIX_NOP;
        default   : state_q <= JIX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction, literal and error capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_q     <= 16'h0000;
      cur_instr_q <= 16'h0000;
      lit_lo_q    <= RST_BYTE;
      illegal_q   <= 1'b0;
    end
    else
    begin
      if ((core_wr || feed2) && hit_instr)
      begin
        instr_q <= pwdata[15:0];
      end
      if (go)
      begin
        cur_instr_q <= instr_q;
        illegal_q   <= 1'b0;
      end
      if (state_q == JIX_DEC && qph_q == 2'h1)
      begin
        lit_lo_q <= cur_instr_q[7:0];
      end
      if (state_q == JIX_DEC && q_last && !is_jmp1 && !is_inc)
      begin
        illegal_q <= 1'b1;
      end
      if (state_q == JIX_EXEC && q_last && !is_jmp2)
      begin
        illegal_q <= 1'b1;
      end
    end
  end

  // program counter; jump writes bits 20:1 in the last phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_q <= RST_PC[PC_W-1:0];
    end
    else if (state_q == JIX_EXEC && q_last && is_jmp2)
    begin
      pc_q <= {jmp_lit, 1'b0};
    end
    else if (core_wr && hit_pc)
    begin
      pc_q <= {pwdata[PC_W-1:1], 1'b0};
    end
    else if (state_q == JIX_DEC && q_last && is_inc)
    begin
      pc_q <= pc_q + 21'h000002;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // increment write-back, accumulator, bank select and flags
  wire               inc_done = (state_q == JIX_DEC) && q_last && is_inc;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wreg_q            <= RST_BYTE;
      bank_select_reg_q <= 4'h0;
      status_q          <= 5'h00;
      ram_we_q          <= 1'b0;
      ram_waddr_q       <= '0;
      ram_wdata_q       <= RST_BYTE;
      mem_addr_q        <= '0;
      busy_q            <= 1'b0;
    end
    else
    begin
      busy_q      <= ~idle | go;
      ram_we_q    <= (inc_done & dest_file) | (core_wr & hit_mdata);
      ram_waddr_q <= inc_done ? eff_addr : mem_addr_q;
      ram_wdata_q <= inc_done ? inc_sum : pwdata[7:0];
      if (inc_done && !dest_file)
      begin
        wreg_q <= inc_sum;
      end
      else if (core_wr && hit_wreg)
      begin
        wreg_q <= pwdata[7:0];
      end
      if (inc_done)
      begin
        status_q <= inc_flags;
      end
      else if (soft_clr || (core_wr && hit_stat))
      begin
        status_q <= soft_clr ? 5'h00 : pwdata[4:0];
      end
      if (core_wr && hit_bank)
      begin
        bank_select_reg_q <= pwdata[3:0];
      end
      if (core_wr && hit_maddr)
      begin
        mem_addr_q <= pwdata[ADDR_W-1:0];
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence jmp_end_s;
    state_q == JIX_EXEC && q_last && is_jmp2;
  endsequence

  jump_pc_load_a : assert property (@(posedge pclk) disable iff (!presetn)
    jmp_end_s |=> pc_q == {$past(jmp_lit), 1'b0})
    else $error("jump did not load pc");
  jump_flags_a : assert property (@(posedge pclk) disable iff (!presetn)
    jmp_end_s |=> $stable(status_q))
    else $error("jump changed flags");
  jump_nop_a : assert property (@(posedge pclk) disable iff (!presetn)
    jmp_end_s |=> (state_q == JIX_NOP)[*4] ##1 state_q == JIX_IDLE)
    else $error("jump second cycle not four phases");
  jump_word1_a : assert property (@(posedge pclk) disable iff (!presetn)
    state_q == JIX_WAIT2 |-> cur_instr_q[15:8] == 8'hEF)
    else $error("second word awaited without jump opcode");
  inc_one_cycle_a : assert property (@(posedge pclk) disable iff (!presetn)
    go |=> (state_q == JIX_DEC)[*4] ##1 (!is_inc || state_q == JIX_IDLE))
    else $error("increment not one cycle");
  inc_to_w_a : assert property (@(posedge pclk) disable iff (!presetn)
    inc_done && !dest_file |=> wreg_q == $past(ram_rdata) + 8'h01 && !ram_we_q)
    else $error("increment to accumulator wrong");
  inc_to_f_a : assert property (@(posedge pclk) disable iff (!presetn)
    inc_done && dest_file |=> ram_we_q && ram_wdata_q == $past(ram_rdata) + 8'h01)
    else $error("increment write-back wrong");
  inc_bank_a : assert property (@(posedge pclk) disable iff (!presetn)
    inc_done && use_bank |=> ram_waddr_q[11:8] == $past(bank_select_reg_q))
    else $error("bank select not used");
  inc_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
    inc_done && ram_rdata == 8'hFF |=> status_q[ST_Z] && status_q[ST_C] && status_q[ST_DC])
    else $error("wrap flags wrong");
endmodule // jix_exec

// *** rtl/jix_pkg.sv ***
// package: encodings, field positions, register map and reset values for the jump/increment executor
package jix_pkg;
  // instruction encodings
  localparam logic [7:0]  JMP_OP1       = 8'hEF;   // first word opcode byte
  localparam logic [3:0]  JMP_PFX2      = 4'hF;    // second word prefix
  localparam logic [5:0]  INC_OP        = 6'h0A;   // increment opcode, six bits
  localparam int          OP_DEST_BIT   = 9;
  localparam int          OP_BANK_BIT   = 8;
  localparam int          PC_W          = 21;
  localparam int          LIT_W         = 20;
  localparam int          ADDR_W        = 12;      // bank:byte data address
  // access bank split: low addresses map to bank 0, high to the top bank
  localparam logic [7:0]  ACC_SPLIT     = 8'h80;
  localparam logic [3:0]  ACC_HI_BANK   = 4'hF;
  // status bit positions
  localparam int          ST_C          = 0;
  localparam int          ST_DC         = 1;
  localparam int          ST_Z          = 2;
  localparam int          ST_OV         = 3;
  localparam int          ST_N          = 4;
  // apb register map (byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;   // bit0 go (pulse), bit1 soft clear
  localparam logic [7:0]  REG_INSTR     = 8'h04;   // instruction word
  localparam logic [7:0]  REG_PC        = 8'h08;   // program counter
  localparam logic [7:0]  REG_WREG      = 8'h0C;   // working accumulator
  localparam logic [7:0]  REG_BANKSEL   = 8'h10;   // bank select register
  localparam logic [7:0]  REG_STATUS    = 8'h14;   // flags
  localparam logic [7:0]  REG_STATE     = 8'h18;   // bit0 busy, bit1 illegal, bit2 awaiting second word
  localparam logic [7:0]  REG_MEM_ADDR  = 8'h1C;   // data memory window address
  localparam logic [7:0]  REG_MEM_DATA  = 8'h20;   // data memory window data
  localparam logic [31:0] RST_PC        = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  // one instruction cycle is four phases
  localparam int          Q_PHASES      = 4;
  typedef enum logic [2:0] {JIX_IDLE, JIX_DEC, JIX_WAIT2, JIX_EXEC, JIX_NOP} jix_state_t;
endpackage

// *** rtl/jix_ram.sv ***
// file register memory, registered read data
`timescale 1ns/1ns
module jix_ram
  import jix_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = 8
)
(
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [2**AW];

  // synchronous write and registered read
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule // jix_ram

// *** rtl/jix_alu.sv ***
// increment adder with flag generation
`timescale 1ns/1ns
module jix_alu
  import jix_pkg::*;
(
  input  wire logic [7:0] opnd,
  output logic      [7:0] sum,
  output logic      [4:0] flags
);
  logic [8:0] full;
  logic [4:0] low;

  // operand plus one, carries and sign overflow
  assign full         = {1'b0, opnd} + 9'h001;
  assign low          = {1'b0, opnd[3:0]} + 5'h01;
  assign sum          = full[7:0];
  assign flags[ST_C]  = full[8];
  assign flags[ST_DC] = low[4];
  assign flags[ST_Z]  = (full[7:0] == 8'h00);
  assign flags[ST_OV] = ~opnd[7] & full[7];
  assign flags[ST_N]  = full[7];
endmodule // jix_alu

// *** verif/jump_and_increment_exec_bench.sv ***
// self-checking bench for the jump and increment executor
`timescale 1ns/1ns
module jump_and_increment_exec_bench
  import jix_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy_q;
  int          error_cnt;
  int          n_tests;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  logic [7:0]  q_adr[$];
  logic        q_err[$];
  logic [31:0] m_e;
  logic [31:0] m_m;
  logic [7:0]  m_a;
  logic        m_r;
  logic [15:0] lf;
  logic [20:0] e_pc;
  logic [7:0]  e_w;
  logic [4:0]  e_st;
  logic [7:0]  v;
  logic [6:0]  f;
  logic [19:0] k;
  logic [31:0] r;

  jix_exec #(.QPH(Q_PHASES)) u_jix_exec (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .busy_q  (busy_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, pseudo-random source, closing task
  always #2 pclk = ~pclk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // expected flags of an increment, worked out independently
  function automatic logic [4:0] inc_fl(input logic [7:0] x);
    logic [7:0] s;
    s = x + 8'h01;
    inc_fl = 5'h00;
    inc_fl[ST_C] = (x == 8'hFF);
    inc_fl[ST_DC] = (x[3:0] == 4'hF);
    inc_fl[ST_Z] = (s == 8'h00);
    inc_fl[ST_OV] = (x == 8'h7F);
    inc_fl[ST_N] = s[7];
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // apb master: setup, access until pready, release plus one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd_v);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd_v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    apb(1'b1, a, d, t);
  endtask

  // read with an expectation noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic er);
    logic [31:0] t;
    q_exp.push_back(e);
    q_msk.push_back(m);
    q_adr.push_back(a);
    q_err.push_back(er);
    apb(1'b0, a, 32'h0000_0000, t);
  endtask

  task automatic mem_set(input logic [11:0] a, input logic [7:0] d);
    wr(REG_MEM_ADDR, {20'h00000, a});
    wr(REG_MEM_DATA, {24'h000000, d});
  endtask

  task automatic mem_chk(input logic [11:0] a, input logic [7:0] e);
    wr(REG_MEM_ADDR, {20'h00000, a});
    repeat (2) @(posedge pclk);
    rd(REG_MEM_DATA, {24'h000000, e}, 32'h0000_00FF, 1'b0);
  endtask

  // wait for the running instruction to finish, bounded
  task automatic wait_idle;
    int n;
    repeat (2) @(posedge pclk);
    n = 0;
    while (busy_q !== 1'b0 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200)
    begin
      error_cnt++;
      $display("mismatch busy_q expected 0 seen 1");
    end
  endtask

  // issue a jump first word and wait until the second word is awaited
  task automatic jump_first(input logic [7:0] lo);
    int n;
    wr(REG_INSTR, {16'h0000, JMP_OP1, lo});
    wr(REG_CTRL, 32'h0000_0001);
    n = 0;
    r = 32'h0000_0000;
    while (r[2] !== 1'b1 && n < 50)
    begin
      apb(1'b0, REG_STATE, 32'h0000_0000, r);
      n++;
    end
    // a poll that runs out, or a busy pin still low, is a mismatch
    n_tests++;
    if (n >= 50 || busy_q !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch busy_q expected 1 seen %b", busy_q);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: compare each completed read with the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && q_adr.size() > 0)
    begin
      m_e = q_exp.pop_front();
      m_m = q_msk.pop_front();
      m_a = q_adr.pop_front();
      m_r = q_err.pop_front();
      n_tests++;
      if (((prdata & m_m) !== (m_e & m_m)) || (pslverr !== m_r))
      begin
        error_cnt++;
        $display("mismatch reg %h expected %h/%b seen %h/%b", m_a, m_e & m_m, m_r, prdata & m_m, pslverr);
      end
    end
  end

  // watchdog against a hang
  initial
  begin
    #200000;
    error_cnt++;
    $display("mismatch watchdog expected finish seen hang");
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    error_cnt = 0;
    n_tests = 0;
    lf = 16'h0034;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    e_pc = 21'h000000;
    e_w = 8'h00;
    e_st = 5'h00;
    rd(REG_PC, 32'h0000_0000, 32'h001F_FFFF, 1'b0);
    rd(REG_STATUS, 32'h0000_0000, 32'h0000_001F, 1'b0);
    rd(8'hFC, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    // increment into the accumulator, access bank low half, boundaries first
    for (int i = 0; i < 6; i++)
    begin
      lf = lfsr_next(lf);
      v = (i == 0) ? 8'h7F : (i == 1) ? 8'hFF : (i == 2) ? 8'h0F : lf[7:0];
      f = lf[14:8];
      mem_set({5'h00, f}, v);
      wr(REG_INSTR, {16'h0000, INC_OP, 2'b00, 1'b0, f});
      wr(REG_CTRL, 32'h0000_0001);
      wait_idle();
      e_w = v + 8'h01;
      e_st = inc_fl(v);
      e_pc = e_pc + 21'h000002;
      rd(REG_WREG, {24'h000000, e_w}, 32'h0000_00FF, 1'b0);
      rd(REG_STATUS, {27'h0, e_st}, 32'h0000_001F, 1'b0);
      rd(REG_PC, {11'h000, e_pc}, 32'h001F_FFFF, 1'b0);
      mem_chk({5'h00, f}, v);
    end
    // increment back into memory through the bank select, top address
    wr(REG_BANKSEL, 32'h0000_0003);
    mem_set(12'h3FF, 8'hFF);
    wr(REG_INSTR, 32'h0000_2BFF);
    wr(REG_CTRL, 32'h0000_0001);
    wait_idle();
    e_pc = e_pc + 21'h000002;
    mem_chk(12'h3FF, 8'h00);
    rd(REG_STATUS, 32'h0000_0007, 32'h0000_001F, 1'b0);
    rd(REG_WREG, {24'h000000, e_w}, 32'h0000_00FF, 1'b0);
    // access bank high half ignores the bank select
    lf = lfsr_next(lf);
    mem_set(12'hF90, lf[7:0]);
    wr(REG_INSTR, 32'h0000_2A90);
    wr(REG_CTRL, 32'h0000_0001);
    wait_idle();
    e_pc = e_pc + 21'h000002;
    e_st = inc_fl(lf[7:0]);
    mem_chk(12'hF90, lf[7:0] + 8'h01);
    // unknown opcode is flagged illegal and moves nothing else
    wr(REG_INSTR, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0001);
    wait_idle();
    rd(REG_STATE, 32'h0000_0002, 32'h0000_0007, 1'b0);
    rd(REG_PC, {11'h000, e_pc}, 32'h001F_FFFF, 1'b0);
    rd(REG_STATUS, {27'h0, e_st}, 32'h0000_001F, 1'b0);
    // jumps to both ends and a random target, refused write meanwhile
    for (int i = 0; i < 3; i++)
    begin
      lf = lfsr_next(lf);
      k = (i == 0) ? 20'hFFFFF : (i == 1) ? 20'h00000 : {lf[3:0], lf};
      jump_first(k[7:0]);
      rd(REG_STATE, 32'h0000_0005, 32'h0000_0007, 1'b0);
      wr(REG_WREG, 32'h0000_0055);
      wr(REG_INSTR, {16'h0000, JMP_PFX2, k[19:8]});
      wait_idle();
      e_pc = {k, 1'b0};
      rd(REG_PC, {11'h000, e_pc}, 32'h001F_FFFF, 1'b0);
      rd(REG_STATUS, {27'h0, e_st}, 32'h0000_001F, 1'b0);
      rd(REG_WREG, {24'h000000, e_w}, 32'h0000_00FF, 1'b0);
    end
    // wrong second word leaves everything and flags illegal
    jump_first(8'h12);
    wr(REG_INSTR, 32'h0000_1234);
    wait_idle();
    rd(REG_STATE, 32'h0000_0002, 32'h0000_0007, 1'b0);
    rd(REG_PC, {11'h000, e_pc}, 32'h001F_FFFF, 1'b0);
    // software writes: pc bit 0 forced low, flags written then cleared
    wr(REG_PC, 32'h0012_3457);
    rd(REG_PC, 32'h0012_3456, 32'h001F_FFFF, 1'b0);
    wr(REG_STATUS, 32'h0000_001F);
    rd(REG_STATUS, 32'h0000_001F, 32'h0000_001F, 1'b0);
    wr(REG_CTRL, 32'h0000_0002);
    rd(REG_STATUS, 32'h0000_0000, 32'h0000_001F, 1'b0);
    tally_and_finish();
  end
endmodule // jump_and_increment_exec_bench
